/* File: src/ocd_top.sv */
// Opcode decoder for data transfer and arithmetic instructions
`timescale 1ns/1ps
`default_nettype none
`include "ocd_defines.svh"

module ocd_top
   import ocd_pkg::*;
(
   // Clock and reset
   input wire logic ref_clk,
   input wire logic rst_n,
   // Instruction byte stream from fetch
   input wire logic byte_valid,
   input wire logic [7:0] byte_data,
   // Decoded instruction
   output logic instr_valid,
   output var ocd_op_type instr_op,
   output logic op_word,
   output logic op_to_reg,
   output logic seg_operand,
   output logic [2:0] operand_sel,
   output logic [1:0] addr_form,
   output logic [2:0] operand_loc,
   output logic mem_operand,
   output logic [15:0] disp_data,
   output logic [15:0] imm_data,
   // Status
   output logic decode_err,
   output logic busy
);
   ocd_dec_if dif ();

   ocd_first_byte u_first (
      .dif(dif)
   );

   ocd_sub_sel u_sub (
      .dif(dif)
   );

   // Held instruction state
   ocd_state_type state_r, state_nxt;
   ocd_op_type op_r;
   ocd_grp_type grp_r;
   ocd_imm_type imm_kind_r;
   logic word_r;
   logic to_reg_r;
   logic sign_r;
   logic seg_r;
   logic seg_chk_r;
   logic disp_two_r;
   logic [1:0] form_r;
   logic [2:0] sel_r;
   logic [2:0] loc_r;
   logic mem_r;
   logic [15:0] disp_r;
   logic [15:0] imm_r;
   logic valid_r, valid_nxt;
   logic err_r, err_nxt;
   logic busy_r;

   // Byte capture strobes
   logic take_opc, take_modrm, take_disp_lo, take_disp_hi, take_imm_lo, take_imm_hi;

   // Carrier drive: opcode classify on live byte, sub-field on addressing byte
   assign dif.opc_byte = byte_data;
   assign dif.sub_grp = grp_r;
   assign dif.sub_reg = byte_data[`OCD_SEL_HI:`OCD_SEL_LO];

   // Addressing byte fields of the byte being taken
   wire [1:0] in_mod = byte_data[`OCD_MOD_HI:`OCD_MOD_LO];
   wire [2:0] in_loc = byte_data[`OCD_LOC_HI:`OCD_LOC_LO];
   wire in_direct = (in_mod == `OCD_MOD_NODISP) && (in_loc == `OCD_LOC_DIRECT);
   wire in_disp_two = (in_mod == `OCD_MOD_DISP16) || in_direct;
   wire in_disp_any = in_disp_two || (in_mod == `OCD_MOD_DISP8);
   wire in_mem = in_mod != `OCD_MOD_REG;

   // Checks made on the addressing byte and on the fixed second byte
   wire grp_bad = (grp_r != OCD_GRP_NONE) && !dif.sub_known;
   wire seg_bad = seg_chk_r && byte_data[`OCD_BIT_SEG_ZERO];
   wire fix_ok = byte_data == `OCD_FIXED_2ND;

   // Immediate length: w forms take two bytes for w, the sign group only for s:w = 01
   wire imm_need = imm_kind_r != OCD_IMM_NONE;
   wire imm_two = (imm_kind_r == OCD_IMM_W) ? word_r : (word_r && !sign_r);
   wire [15:0] imm_lo_val = sign_r ? {{8{byte_data[7]}}, byte_data} : {8'h00, byte_data};
   wire [15:0] disp_lo_val = {{8{byte_data[7]}}, byte_data};

   // Next state and capture strobes
   always_comb
   begin
      state_nxt = state_r;
      valid_nxt = 1'b0;
      err_nxt = 1'b0;
      take_opc = 1'b0;
      take_modrm = 1'b0;
      take_disp_lo = 1'b0;
      take_disp_hi = 1'b0;
      take_imm_lo = 1'b0;
      take_imm_hi = 1'b0;
      if (byte_valid)
      begin
         case (state_r)
            OCD_ST_OPC:
            begin
               take_opc = 1'b1;
               if (!dif.fb_known)
                  err_nxt = 1'b1;
               else if (dif.fb_fixed2)
                  state_nxt = OCD_ST_FIX;
               else if (dif.fb_modrm)
                  state_nxt = OCD_ST_MODRM;
               else if (dif.fb_imm != OCD_IMM_NONE)
                  state_nxt = OCD_ST_IMM_LO;
               else
                  valid_nxt = 1'b1;
            end
            OCD_ST_MODRM:
            begin
               take_modrm = 1'b1;
               if (grp_bad || seg_bad)
               begin
                  err_nxt = 1'b1;
                  state_nxt = OCD_ST_OPC;
               end
               else if (in_disp_any)
                  state_nxt = OCD_ST_DISP_LO;
               else if (imm_need)
                  state_nxt = OCD_ST_IMM_LO;
               else
               begin
                  valid_nxt = 1'b1;
                  state_nxt = OCD_ST_OPC;
               end
            end
            OCD_ST_DISP_LO:
            begin
               take_disp_lo = 1'b1;
               if (disp_two_r)
                  state_nxt = OCD_ST_DISP_HI;
               else if (imm_need)
                  state_nxt = OCD_ST_IMM_LO;
               else
               begin
                  valid_nxt = 1'b1;
                  state_nxt = OCD_ST_OPC;
               end
            end
            OCD_ST_DISP_HI:
            begin
               take_disp_hi = 1'b1;
               if (imm_need)
                  state_nxt = OCD_ST_IMM_LO;
               else
               begin
                  valid_nxt = 1'b1;
                  state_nxt = OCD_ST_OPC;
               end
            end
            OCD_ST_IMM_LO:
            begin
               take_imm_lo = 1'b1;
               if (imm_two)
                  state_nxt = OCD_ST_IMM_HI;
               else
               begin
                  valid_nxt = 1'b1;
                  state_nxt = OCD_ST_OPC;
               end
            end
            OCD_ST_IMM_HI:
            begin
               take_imm_hi = 1'b1;
               valid_nxt = 1'b1;
               state_nxt = OCD_ST_OPC;
            end
            OCD_ST_FIX:
            begin
               valid_nxt = fix_ok;
               err_nxt = !fix_ok;
               state_nxt = OCD_ST_OPC;
            end
            default:
               state_nxt = OCD_ST_OPC;
         endcase
      end
   end

   // State and status flags
   always_ff @(posedge ref_clk)
   begin
      if (!rst_n)
      begin
         state_r <= OCD_ST_OPC;
         valid_r <= 1'b0;
         err_r <= 1'b0;
         busy_r <= 1'b0;
      end
      else
      begin
         state_r <= state_nxt;
         valid_r <= valid_nxt;
         err_r <= err_nxt;
         busy_r <= state_nxt != OCD_ST_OPC;
      end
   end

   // Opcode attributes, latched with the first byte
   always_ff @(posedge ref_clk)
   begin
      if (!rst_n)
      begin
         grp_r <= OCD_GRP_NONE;
         imm_kind_r <= OCD_IMM_NONE;
         word_r <= 1'b0;
         to_reg_r <= 1'b0;
         sign_r <= 1'b0;
         seg_r <= 1'b0;
         seg_chk_r <= 1'b0;
      end
      else if (take_opc)
      begin
         grp_r <= dif.fb_grp;
         imm_kind_r <= dif.fb_imm;
         word_r <= dif.fb_word;
         to_reg_r <= dif.fb_to_reg;
         sign_r <= dif.fb_sign;
         seg_r <= dif.fb_seg;
         seg_chk_r <= dif.fb_seg_chk;
      end
   end

   // Operation: first byte, then refined by the sub-field for grouped opcodes
   always_ff @(posedge ref_clk)
   begin
      if (!rst_n)
         op_r <= OCD_OP_NONE;
      else if (take_opc)
         op_r <= dif.fb_op;
      else if (take_modrm && (grp_r != OCD_GRP_NONE))
         op_r <= dif.sub_op;
   end

   // Addressing byte fields
   always_ff @(posedge ref_clk)
   begin
      if (!rst_n || take_opc)
      begin
         form_r <= 2'h0;
         sel_r <= 3'h0;
         loc_r <= 3'h0;
         mem_r <= 1'b0;
         disp_two_r <= 1'b0;
      end
      else if (take_modrm)
      begin
         form_r <= in_mod;
         sel_r <= byte_data[`OCD_SEL_HI:`OCD_SEL_LO];
         loc_r <= in_loc;
         mem_r <= in_mem;
         disp_two_r <= in_disp_two;
      end
   end

   // Displacement and immediate data
   always_ff @(posedge ref_clk)
   begin
      if (!rst_n || take_opc)
      begin
         disp_r <= `OCD_RST_WORD;
         imm_r <= `OCD_RST_WORD;
      end
      else
      begin
         if (take_disp_lo)
            disp_r <= disp_lo_val;
         if (take_disp_hi)
            disp_r[15:8] <= byte_data;
         if (take_imm_lo)
            imm_r <= imm_lo_val;
         if (take_imm_hi)
            imm_r[15:8] <= byte_data;
      end
   end

   // Outputs straight from flip-flops
   assign instr_valid = valid_r;
   assign instr_op = op_r;
   assign op_word = word_r;
   assign op_to_reg = to_reg_r;
   assign seg_operand = seg_r;
   assign operand_sel = sel_r;
   assign addr_form = form_r;
   assign operand_loc = loc_r;
   assign mem_operand = mem_r;
   assign disp_data = disp_r;
   assign imm_data = imm_r;
   assign decode_err = err_r;
   assign busy = busy_r;
endmodule

`default_nettype wire

/* File: src/ocd_defines.svh */
// Opcode patterns, masks, field positions and reset values for the opcode decoder
`ifndef OCD_DEFINES_SVH
`define OCD_DEFINES_SVH

// Masks that ignore the direction/sign and size bits, the size bit only, or no bit
`define OCD_MSK_DW 8'hFC
`define OCD_MSK_W 8'hFE
`define OCD_MSK_ALL 8'hFF

// Two-bit-variable first bytes (xxxxxxdw / xxxxxxsw)
`define OCD_ADD_RM 8'h00
`define OCD_ADC_RM 8'h10
`define OCD_SUB_RM 8'h28
`define OCD_SBB_RM 8'h18
`define OCD_IMM_GRP 8'h80

// One-bit-variable first bytes (xxxxxxxw)
`define OCD_ADD_ACC 8'h04
`define OCD_ADC_ACC 8'h14
`define OCD_SUB_ACC 8'h2C
`define OCD_SBB_ACC 8'h1C
`define OCD_UNARY_GRP 8'hF6

// Fixed first bytes
`define OCD_SEG_IN 8'h8E
`define OCD_SEG_OUT 8'h8C
`define OCD_XLT 8'hD7
`define OCD_EA_LOAD 8'h8D
`define OCD_FAR_DS 8'hC5
`define OCD_FAR_ES 8'hC4
`define OCD_FLG_TO_AH 8'h9F
`define OCD_AH_TO_FLG 8'h9E
`define OCD_ASC_PROD 8'hD4
`define OCD_ASC_QUOT 8'hD5
`define OCD_SEXT_B 8'h98
`define OCD_SEXT_W 8'h99
`define OCD_ASC_SUM 8'h37
`define OCD_BCD_SUM 8'h27
`define OCD_ASC_DIFF 8'h3F
`define OCD_BCD_DIFF 8'h2F

// Fixed second byte of the two ASCII product and quotient adjust opcodes
`define OCD_FIXED_2ND 8'h0A

// Sub-field values in bits 5:3 of the addressing byte
`define OCD_SUB_ADD 3'h0
`define OCD_SUB_ADC 3'h2
`define OCD_SUB_SBB 3'h3
`define OCD_SUB_SUBT 3'h5
`define OCD_SUB_UPROD 3'h4
`define OCD_SUB_SPROD 3'h5
`define OCD_SUB_UQUOT 3'h6
`define OCD_SUB_SQUOT 3'h7

// Opcode and addressing byte field positions
`define OCD_BIT_SIZE 0
`define OCD_BIT_DIR 1
`define OCD_BIT_SEG_ZERO 5
`define OCD_MOD_HI 7
`define OCD_MOD_LO 6
`define OCD_SEL_HI 5
`define OCD_SEL_LO 3
`define OCD_LOC_HI 2
`define OCD_LOC_LO 0

// Addressing forms
`define OCD_MOD_NODISP 2'h0
`define OCD_MOD_DISP8 2'h1
`define OCD_MOD_DISP16 2'h2
`define OCD_MOD_REG 2'h3
`define OCD_LOC_DIRECT 3'h6

// Reset values
`define OCD_RST_BYTE 8'h00
`define OCD_RST_WORD 16'h0000

`endif

/* File: src/ocd_pkg.sv */
// Types shared by the opcode decoder modules
package ocd_pkg;

   // Decoded operation
   typedef enum logic [4:0] {
      OCD_OP_NONE,
      OCD_OP_ADD,
      OCD_OP_SUM_WITH_CARRY_OP,
      OCD_OP_SUBTRACT,
      OCD_OP_DIFF_WITH_BORROW_OP,
      OCD_OP_TRANSFER_OP,
      OCD_OP_TABLE_LOOKUP_OP,
      OCD_OP_EFFECTIVE_ADDR_LOAD_OP,
      OCD_OP_FAR_POINTER_LOAD_DATA_SEG,
      OCD_OP_FAR_POINTER_LOAD_EXTRA_SEG,
      OCD_OP_FLAGS_TO_HIGH_ACC,
      OCD_OP_HIGH_ACC_TO_FLAGS,
      OCD_OP_UNSIGNED_PRODUCT_OP,
      OCD_OP_SIGNED_PRODUCT_OP,
      OCD_OP_UNSIGNED_QUOTIENT_OP,
      OCD_OP_SIGNED_QUOTIENT_OP,
      OCD_OP_ASCII_PRODUCT_FIX,
      OCD_OP_ASCII_QUOTIENT_PREP,
      OCD_OP_BYTE_SIGN_EXTEND,
      OCD_OP_WORD_SIGN_EXTEND,
      OCD_OP_ASCII_SUM_FIX,
      OCD_OP_BCD_SUM_FIX,
      OCD_OP_ASCII_DIFF_FIX,
      OCD_OP_BCD_DIFF_FIX
   } ocd_op_type;

   // Opcode groups resolved by the addressing byte
   typedef enum logic [1:0] {
      OCD_GRP_NONE,
      OCD_GRP_IMM,
      OCD_GRP_UNARY
   } ocd_grp_type;

   // Immediate data length rule
   typedef enum logic [1:0] {
      OCD_IMM_NONE,
      OCD_IMM_W,
      OCD_IMM_SW
   } ocd_imm_type;

   // Byte collection states
   typedef enum logic [2:0] {
      OCD_ST_OPC,
      OCD_ST_MODRM,
      OCD_ST_DISP_LO,
      OCD_ST_DISP_HI,
      OCD_ST_IMM_LO,
      OCD_ST_IMM_HI,
      OCD_ST_FIX
   } ocd_state_type;

endpackage

/* File: src/ocd_dec_if.sv */
// Carrier between the decoder top and its first-byte and sub-field decoders
`timescale 1ns/1ps
`default_nettype none

interface ocd_dec_if;
   import ocd_pkg::*;

   // First byte and its classification
   logic [7:0] opc_byte;
   ocd_op_type fb_op;
   ocd_grp_type fb_grp;
   ocd_imm_type fb_imm;
   logic fb_known;
   logic fb_modrm;
   logic fb_fixed2;
   logic fb_word;
   logic fb_to_reg;
   logic fb_sign;
   logic fb_seg;
   logic fb_seg_chk;

   // Sub-field selection
   ocd_grp_type sub_grp;
   logic [2:0] sub_reg;
   ocd_op_type sub_op;
   logic sub_known;

   modport top (
      output opc_byte, sub_grp, sub_reg,
      input fb_op, fb_grp, fb_imm, fb_known, fb_modrm, fb_fixed2, fb_word,
      input fb_to_reg, fb_sign, fb_seg, fb_seg_chk, sub_op, sub_known
   );
   modport first (
      input opc_byte,
      output fb_op, fb_grp, fb_imm, fb_known, fb_modrm, fb_fixed2, fb_word,
      output fb_to_reg, fb_sign, fb_seg, fb_seg_chk
   );
   modport sub (
      input sub_grp, sub_reg,
      output sub_op, sub_known
   );
endinterface

`default_nettype wire

/* File: src/ocd_first_byte.sv */
// First-byte classifier of the opcode decoder
`timescale 1ns/1ps
`default_nettype none
`include "ocd_defines.svh"

module ocd_first_byte
   import ocd_pkg::*;
(
   // Decoder carrier
   ocd_dec_if.first dif
);
   wire [7:0] b = dif.opc_byte;

   // Pattern matches
   wire m_add_rm = (b & `OCD_MSK_DW) == `OCD_ADD_RM;
   wire m_add_acc = (b & `OCD_MSK_W) == `OCD_ADD_ACC;
   wire m_adc_rm = (b & `OCD_MSK_DW) == `OCD_ADC_RM;
   wire m_adc_acc = (b & `OCD_MSK_W) == `OCD_ADC_ACC;
   wire m_sub_rm = (b & `OCD_MSK_DW) == `OCD_SUB_RM;
   wire m_sub_acc = (b & `OCD_MSK_W) == `OCD_SUB_ACC;
   wire m_sbb_rm = (b & `OCD_MSK_DW) == `OCD_SBB_RM;
   wire m_sbb_acc = (b & `OCD_MSK_W) == `OCD_SBB_ACC;
   wire m_imm_grp = (b & `OCD_MSK_DW) == `OCD_IMM_GRP;
   wire m_unary = (b & `OCD_MSK_W) == `OCD_UNARY_GRP;
   wire m_seg_in = b == `OCD_SEG_IN;
   wire m_seg_out = b == `OCD_SEG_OUT;
   wire m_xlt = b == `OCD_XLT;
   wire m_eal = b == `OCD_EA_LOAD;
   wire m_fds = b == `OCD_FAR_DS;
   wire m_fes = b == `OCD_FAR_ES;
   wire m_fl2a = b == `OCD_FLG_TO_AH;
   wire m_a2fl = b == `OCD_AH_TO_FLG;
   wire m_apx = b == `OCD_ASC_PROD;
   wire m_aqp = b == `OCD_ASC_QUOT;
   wire m_sxb = b == `OCD_SEXT_B;
   wire m_sxw = b == `OCD_SEXT_W;
   wire m_asf = b == `OCD_ASC_SUM;
   wire m_bsf = b == `OCD_BCD_SUM;
   wire m_adf = b == `OCD_ASC_DIFF;
   wire m_bdf = b == `OCD_BCD_DIFF;

   // Forms that carry d and w bits, or only w; fixed opcodes that are word-sized, load a register, or are single bytes
   wire dw_form = m_add_rm | m_adc_rm | m_sub_rm | m_sbb_rm;
   wire w_form = m_add_acc | m_adc_acc | m_sub_acc | m_sbb_acc | m_imm_grp | m_unary;
   wire fixed_word = m_seg_in | m_seg_out | m_eal | m_fds | m_fes | m_sxw;
   wire to_reg_fixed = m_seg_in | m_eal | m_fds | m_fes;
   wire single = m_xlt | m_fl2a | m_a2fl | m_sxb | m_sxw | m_asf | m_bsf | m_adf | m_bdf;

   // Operation select
   assign dif.fb_op = (m_add_rm | m_add_acc) ? OCD_OP_ADD :
      (m_adc_rm | m_adc_acc) ? OCD_OP_SUM_WITH_CARRY_OP :
      (m_sub_rm | m_sub_acc) ? OCD_OP_SUBTRACT :
      (m_sbb_rm | m_sbb_acc) ? OCD_OP_DIFF_WITH_BORROW_OP :
      (m_seg_in | m_seg_out) ? OCD_OP_TRANSFER_OP :
      m_xlt ? OCD_OP_TABLE_LOOKUP_OP :
      m_eal ? OCD_OP_EFFECTIVE_ADDR_LOAD_OP :
      m_fds ? OCD_OP_FAR_POINTER_LOAD_DATA_SEG :
      m_fes ? OCD_OP_FAR_POINTER_LOAD_EXTRA_SEG :
      m_fl2a ? OCD_OP_FLAGS_TO_HIGH_ACC :
      m_a2fl ? OCD_OP_HIGH_ACC_TO_FLAGS :
      m_apx ? OCD_OP_ASCII_PRODUCT_FIX :
      m_aqp ? OCD_OP_ASCII_QUOTIENT_PREP :
      m_sxb ? OCD_OP_BYTE_SIGN_EXTEND :
      m_sxw ? OCD_OP_WORD_SIGN_EXTEND :
      m_asf ? OCD_OP_ASCII_SUM_FIX :
      m_bsf ? OCD_OP_BCD_SUM_FIX :
      m_adf ? OCD_OP_ASCII_DIFF_FIX :
      m_bdf ? OCD_OP_BCD_DIFF_FIX : OCD_OP_NONE;

   // Length, size and direction attributes
   assign dif.fb_grp = m_imm_grp ? OCD_GRP_IMM : (m_unary ? OCD_GRP_UNARY : OCD_GRP_NONE);
   assign dif.fb_imm = m_imm_grp ? OCD_IMM_SW :
      ((m_add_acc | m_adc_acc | m_sub_acc | m_sbb_acc) ? OCD_IMM_W : OCD_IMM_NONE);
   assign dif.fb_modrm = dw_form | m_imm_grp | m_unary | m_seg_in | m_seg_out | m_eal
      | m_fds | m_fes;
   assign dif.fb_fixed2 = m_apx | m_aqp;
   assign dif.fb_word = ((dw_form | w_form) & b[`OCD_BIT_SIZE]) | fixed_word;
   assign dif.fb_to_reg = (dw_form & b[`OCD_BIT_DIR]) | to_reg_fixed;
   assign dif.fb_sign = m_imm_grp & b[`OCD_BIT_DIR];
   assign dif.fb_seg = m_seg_in | m_seg_out;
   assign dif.fb_seg_chk = m_seg_in;
   assign dif.fb_known = dif.fb_modrm | dif.fb_fixed2 | single | m_add_acc | m_adc_acc
      | m_sub_acc | m_sbb_acc;
endmodule

`default_nettype wire

/* File: src/ocd_sub_sel.sv */
// Sub-field operation selector for opcode groups resolved by the addressing byte
`timescale 1ns/1ps
`default_nettype none
`include "ocd_defines.svh"

module ocd_sub_sel
   import ocd_pkg::*;
(
   // Decoder carrier
   ocd_dec_if.sub dif
);
   // Immediate arithmetic group
   wire imm_g = dif.sub_grp == OCD_GRP_IMM;
   wire [2:0] r = dif.sub_reg;
   wire imm_add = imm_g & (r == `OCD_SUB_ADD);
   wire imm_adc = imm_g & (r == `OCD_SUB_ADC);
   wire imm_sbb = imm_g & (r == `OCD_SUB_SBB);
   wire imm_sub = imm_g & (r == `OCD_SUB_SUBT);

   // Product and quotient group
   wire un_g = dif.sub_grp == OCD_GRP_UNARY;
   wire un_up = un_g & (r == `OCD_SUB_UPROD);
   wire un_sp = un_g & (r == `OCD_SUB_SPROD);
   wire un_uq = un_g & (r == `OCD_SUB_UQUOT);
   wire un_sq = un_g & (r == `OCD_SUB_SQUOT);

   // Selected operation; other sub-fields are not handled here
   assign dif.sub_op = imm_add ? OCD_OP_ADD :
      imm_adc ? OCD_OP_SUM_WITH_CARRY_OP :
      imm_sbb ? OCD_OP_DIFF_WITH_BORROW_OP :
      imm_sub ? OCD_OP_SUBTRACT :
      un_up ? OCD_OP_UNSIGNED_PRODUCT_OP :
      un_sp ? OCD_OP_SIGNED_PRODUCT_OP :
      un_uq ? OCD_OP_UNSIGNED_QUOTIENT_OP :
      un_sq ? OCD_OP_SIGNED_QUOTIENT_OP : OCD_OP_NONE;
   assign dif.sub_known = imm_add | imm_adc | imm_sbb | imm_sub | un_up | un_sp | un_uq
      | un_sq;
endmodule

`default_nettype wire

/* File: verification/ocd_top_chk.sv */
// Port-level property checker for the opcode decoder
`timescale 1ns/1ps
`default_nettype none

module ocd_top_chk
   import ocd_pkg::*;
(
   // Clock and reset
   input wire logic ref_clk,
   input wire logic rst_n,
   // Byte stream
   input wire logic byte_valid,
   input wire logic [7:0] byte_data,
   // Decoded instruction
   input wire logic instr_valid,
   input wire ocd_op_type instr_op,
   input wire logic op_word,
   input wire logic op_to_reg,
   input wire logic seg_operand,
   input wire logic [2:0] operand_sel,
   input wire logic [1:0] addr_form,
   input wire logic mem_operand,
   // Status
   input wire logic decode_err,
   input wire logic busy
);
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (!rst_n);
   logic [7:0] opc_r;
   logic nth_r;
   logic [1:0] sub_r;
   ocd_op_type one_r;

   // Operation of each single-byte opcode
   function automatic ocd_op_type one_op(input logic [7:0] b);
      case (b)
         8'hD7: return OCD_OP_TABLE_LOOKUP_OP;
         8'h9F: return OCD_OP_FLAGS_TO_HIGH_ACC;
         8'h9E: return OCD_OP_HIGH_ACC_TO_FLAGS;
         8'h98: return OCD_OP_BYTE_SIGN_EXTEND;
         8'h99: return OCD_OP_WORD_SIGN_EXTEND;
         8'h37: return OCD_OP_ASCII_SUM_FIX;
         8'h27: return OCD_OP_BCD_SUM_FIX;
         8'h3F: return OCD_OP_ASCII_DIFF_FIX;
         8'h2F: return OCD_OP_BCD_DIFF_FIX;
         default: return OCD_OP_NONE;
      endcase
   endfunction

   // Remember the opcode and whether the next byte is the second one
   always_ff @(posedge ref_clk)
   begin
      if (!rst_n)
      begin
         opc_r <= 8'h00;
         nth_r <= 1'b0;
      end
      else if (byte_valid)
      begin
         nth_r <= !busy;
         sub_r <= byte_data[4:3];
         one_r <= one_op(byte_data);
         if (!busy)
            opc_r <= byte_data;
      end
   end

   property p_single;
      byte_valid && !busy && one_op(byte_data) != OCD_OP_NONE |=> instr_valid && instr_op == one_r;
   endproperty
   a_single: assert property (p_single)
      else $error("single byte opcode decoded wrongly");
   property p_word;
      instr_valid && opc_r[7:6] == 2'b00 && opc_r[2:1] != 2'b11 |-> op_word == opc_r[0];
   endproperty
   a_word: assert property (p_word)
      else $error("operand size does not follow opcode bit 0");
   property p_dir;
      instr_valid && opc_r[7:6] == 2'b00 && !opc_r[2] |-> op_to_reg == opc_r[1];
   endproperty
   a_dir: assert property (p_dir)
      else $error("direction does not follow opcode bit 1");
   property p_mem;
      instr_valid && opc_r[7:6] == 2'b00 && !opc_r[2] |-> mem_operand == (addr_form != 2'h3);
   endproperty
   a_mem: assert property (p_mem)
      else $error("memory operand flag wrong for addressing form");
   property p_seg_in;
      instr_valid && opc_r == 8'h8E |-> seg_operand && op_to_reg && !operand_sel[2];
   endproperty
   a_seg_in: assert property (p_seg_in)
      else $error("segment load fields wrong");
   property p_seg_bad;
      byte_valid && busy && nth_r && opc_r == 8'h8E && byte_data[5] |=> decode_err && !instr_valid;
   endproperty
   a_seg_bad: assert property (p_seg_bad)
      else $error("segment load with bit 5 set not refused");
   property p_seg_out;
      instr_valid && opc_r == 8'h8C |-> seg_operand && !op_to_reg;
   endproperty
   a_seg_out: assert property (p_seg_out)
      else $error("segment store fields wrong");
   property p_unary;
      byte_valid && busy && nth_r && opc_r[7:1] == 7'h7B && byte_data[7:5] == 3'b111
         |=> instr_valid && instr_op == ocd_op_type'({3'b011, sub_r});
   endproperty
   a_unary: assert property (p_unary)
      else $error("product or quotient sub-field decoded wrongly");
   property p_fix_bad;
      byte_valid && busy && nth_r && opc_r[7:1] == 7'h6A && byte_data != 8'h0A
         |=> decode_err && !instr_valid;
   endproperty
   a_fix_bad: assert property (p_fix_bad)
      else $error("wrong fixed second byte not refused");
   property p_imm_wait;
      (byte_valid && !busy && byte_data == 8'h05) ##1 (byte_valid && busy)
         |=> busy && !instr_valid;
   endproperty
   a_imm_wait: assert property (p_imm_wait)
      else $error("word immediate ended after one data byte");

   // Main scenarios
   c_add: cover property (instr_valid && instr_op == OCD_OP_ADD);
   c_err: cover property (decode_err);
   c_mem: cover property (instr_valid && mem_operand);
endmodule

bind ocd_top ocd_top_chk u_chk (.ref_clk, .rst_n, .byte_valid, .byte_data, .instr_valid,
   .instr_op, .op_word, .op_to_reg, .seg_operand, .operand_sel, .addr_form, .mem_operand,
   .decode_err, .busy);

`default_nettype wire

/* File: verification/opcode_decode_data_arith_bench.sv */
// Self-checking bench for the opcode decoder
`timescale 1ns/1ps
`default_nettype none

module opcode_decode_data_arith_bench
   import ocd_pkg::*;
;
   // Clock, reset and byte stream
   logic ref_clk = 1'b0;
   logic rst_n = 1'b0;
   logic byte_valid = 1'b0;
   logic [7:0] byte_data = 8'h00;
   // Decoder outputs
   logic instr_valid, op_word, op_to_reg, seg_operand, mem_operand, decode_err, busy;
   ocd_op_type instr_op;
   logic [2:0] operand_sel, operand_loc;
   logic [1:0] addr_form;
   logic [15:0] disp_data, imm_data;
   int err_total = 0;
   int checks_done = 0;

   ocd_top dut (.ref_clk, .rst_n, .byte_valid, .byte_data, .instr_valid, .instr_op, .op_word,
      .op_to_reg, .seg_operand, .operand_sel, .addr_form, .operand_loc, .mem_operand,
      .disp_data, .imm_data, .decode_err, .busy);

   // 40 MHz clock
   initial
   begin
      forever #12.5 ref_clk = ~ref_clk;
   end

   // Compare one value and count it
   task automatic chk(input logic [63:0] seen, input logic [63:0] exp);
      checks_done++;
      if (seen !== exp)
      begin
         err_total++;
         $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask

   // Drive a byte string, first byte highest, and look one cycle after the last
   task automatic run(input logic [47:0] s, input int n);
      @(posedge ref_clk);
      for (int i = n - 1; i >= 0; i--)
      begin
         byte_valid <= 1'b1;
         byte_data <= s[8*i +: 8];
         @(posedge ref_clk);
      end
      byte_valid <= 1'b0;
      @(negedge ref_clk);
   endtask

   // Decoded instruction with all fields
   task automatic rm(input logic [47:0] s, input int n, input ocd_op_type op,
      input logic [2:0] wdg, input logic [7:0] m, input logic mem, input logic [15:0] disp,
      input logic [15:0] imm);
      run(s, n);
      chk({instr_valid, decode_err, instr_op, op_word, op_to_reg, seg_operand}, {2'b10, op, wdg});
      chk({addr_form, operand_sel, operand_loc, mem_operand}, {m, mem});
      chk({disp_data, imm_data, busy}, {disp, imm, 1'b0});
   endtask

   // Refused byte string
   task automatic er(input logic [47:0] s, input int n);
      run(s, n);
      chk({decode_err, instr_valid}, 2'b10);
   endtask

   // Single-byte opcodes back to back, each judged in the cycle after it
   task automatic t_single;
      logic [7:0] b[9] = '{8'hD7, 8'h9F, 8'h9E, 8'h98, 8'h99, 8'h37, 8'h27, 8'h3F, 8'h2F};
      ocd_op_type e[9] = '{OCD_OP_TABLE_LOOKUP_OP, OCD_OP_FLAGS_TO_HIGH_ACC,
         OCD_OP_HIGH_ACC_TO_FLAGS, OCD_OP_BYTE_SIGN_EXTEND, OCD_OP_WORD_SIGN_EXTEND,
         OCD_OP_ASCII_SUM_FIX, OCD_OP_BCD_SUM_FIX, OCD_OP_ASCII_DIFF_FIX, OCD_OP_BCD_DIFF_FIX};
      @(posedge ref_clk);
      for (int i = 0; i < 10; i++)
      begin
         byte_valid <= (i < 9);
         byte_data <= b[i % 9];
         @(negedge ref_clk);
         if (i > 0)
            chk({instr_valid, op_word, instr_op},
               {1'b1, i == 5, e[i-1]});
         @(posedge ref_clk);
      end
      byte_valid <= 1'b0;
      $display("single byte test done");
   endtask

   // Accumulator, register and memory forms with displacement and data
   task automatic t_forms;
      rm(24'h053412, 3, OCD_OP_ADD, 3'b100, 8'h00, 0, 16'h0000, 16'h1234);
      rm(16'h047F, 2, OCD_OP_ADD, 3'b000, 8'h00, 0, 16'h0000, 16'h007F);
      rm(24'h15FF00, 3, OCD_OP_SUM_WITH_CARRY_OP, 3'b100, 8'h00, 0, 16'h0, 16'h00FF);
      rm(16'h2C80, 2, OCD_OP_SUBTRACT, 3'b000, 8'h00, 0, 16'h0000, 16'h0080);
      rm(16'h03C1, 2, OCD_OP_ADD, 3'b110, 8'hC1, 0, 16'h0000, 16'h0000);
      rm(24'h124608, 3, OCD_OP_SUM_WITH_CARRY_OP, 3'b010, 8'h46, 1, 16'h8, 16'h0);
      rm(32'h28863412, 4, OCD_OP_SUBTRACT, 3'b000, 8'h86, 1, 16'h1234, 16'h0000);
      rm(24'h1A46F0, 3, OCD_OP_DIFF_WITH_BORROW_OP, 3'b010, 8'h46, 1, 16'hFFF0, 16'h0);
      rm(32'h19067856, 4, OCD_OP_DIFF_WITH_BORROW_OP, 3'b100, 8'h06, 1, 16'h5678, 16'h0);
      rm(48'h810634127856, 6, OCD_OP_ADD, 3'b100, 8'h06, 1, 16'h1234, 16'h5678);
      rm(24'h83D8F0, 3, OCD_OP_DIFF_WITH_BORROW_OP, 3'b100, 8'hD8, 0, 16'h0, 16'hFFF0);
      rm(24'h80D805, 3, OCD_OP_DIFF_WITH_BORROW_OP, 3'b000, 8'hD8, 0, 16'h0, 16'h0005);
      rm(16'h8ED8, 2, OCD_OP_TRANSFER_OP, 3'b111, 8'hD8, 0, 16'h0000, 16'h0000);
      rm(32'h8C1E3412, 4, OCD_OP_TRANSFER_OP, 3'b101, 8'h1E, 1, 16'h1234, 16'h0000);
      rm(24'h8D4610, 3, OCD_OP_EFFECTIVE_ADDR_LOAD_OP, 3'b110, 8'h46, 1, 16'h0010, 16'h0);
      rm(32'hC50E0020, 4, OCD_OP_FAR_POINTER_LOAD_DATA_SEG, 3'h6, 8'h0E, 1, 16'h2000, 0);
      rm(24'hC45EFE, 3, OCD_OP_FAR_POINTER_LOAD_EXTRA_SEG, 3'b110, 8'h5E, 1, 16'hFFFE, 0);
      $display("operand forms test done");
   endtask

   // Product and quotient sub-fields for both operand sizes
   task automatic t_unary;
      for (int k = 8; k < 16; k++)
      begin
         run(48'({7'h7B, k[0], 2'b11, k[3:1], 3'h2}), 2);
         chk({instr_valid, instr_op}, {1'b1, 5'd12 + 5'(k[2:1])});
         chk(op_word, k[0]);
      end
      $display("product and quotient test done");
   endtask

   // Fixed second bytes, refused bytes and recovery after a refusal
   task automatic t_fixed;
      run(16'hD40A, 2);
      chk({instr_valid, instr_op}, {1'b1, OCD_OP_ASCII_PRODUCT_FIX});
      run(16'hD50A, 2);
      chk({instr_valid, instr_op}, {1'b1, OCD_OP_ASCII_QUOTIENT_PREP});
      er(16'hD40B, 2);
      er(16'hD500, 2);
      er(16'h8EF8, 2);
      er(8'h88, 1);
      run(8'h37, 1);
      chk({instr_valid, instr_op}, {1'b1, OCD_OP_ASCII_SUM_FIX});
      $display("fixed byte and refusal test done");
   endtask

   // Print the counts and the verdict, then stop
   task automatic report_and_stop;
      $display("checks %0d mismatches %0d", checks_done, err_total);
      if (err_total == 0 && checks_done > 0)
         $display("[ PASS ]");
      else
         $display("[ FAIL ]");
      $finish;
   endtask

   // Reset, then the scenarios
   initial
   begin
      repeat (5) @(posedge ref_clk);
      rst_n <= 1'b1;
      t_single();
      t_forms();
      t_unary();
      t_fixed();
      report_and_stop();
   end
endmodule

`default_nettype wire
